/* File: rtl/dcr_pkg.sv */
// Purpose: Constants, register map and state type of the disturbance capture recorder.
// Assumes: 100 MHz core clock, 50 Hz fundamental, 32 samples per power cycle.
// Notes: All lengths except the limit, set in power cycles, are counted in stored sample words.
// Behaviour
// [RQ1] Sample all channels 32 times per cycle
// [RQ2] Start on OR of eight selected triggers
// [RQ3] Lock out until causing triggers clear; code keeps the mask until the next record, so a returning cause stays locked
// [RQ4] Shared storage holds 120 s of samples
// [RQ5] Record length configurable, at most 15 s
// [RQ6] Pre and post lengths are percentages
// [RQ7] Pre-trigger portion always full pre length
// [RQ8] Event lasts min(trigger, limit minus pre)
// [RQ9] Post lasts min(post, remaining time)
// [RQ10] Always stop when record limit elapses
// [RQ11] Overwrite on: drop oldest records when full
// [RQ12] Overwrite off: refuse records until cleared
// [RQ13] Manual trigger starts a normal record
// [RQ14] Confirmed delete erases one or all
// [RQ15] Record holds pre-trigger samples then later ones
// [RQ16] Storage allocated per record, not fixed slots
// [RQ17] Circular history feeds pre-trigger data
package dcr_pkg;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int FUND_HZ = 50;
	localparam int SAMPLES_PER_CYCLE = 32;
	localparam int SPC_SHIFT = 5;
	localparam int SAMPLE_PERIOD_NS = 1_000_000_000 / (FUND_HZ * SAMPLES_PER_CYCLE);
	localparam int SAMPLE_DIV = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 17;

	// ==========================================
	// Storage sizes
	localparam int STORE_S = 120;
	localparam int LIMIT_S = 15;
	localparam int STORE_WORDS = STORE_S * FUND_HZ * SAMPLES_PER_CYCLE;
	localparam int LIMIT_CYCLES_MAX = LIMIT_S * FUND_HZ;
	localparam int HIST_WORDS = LIMIT_CYCLES_MAX * SAMPLES_PER_CYCLE;
	localparam int SADDR_W = 18;
	localparam int HADDR_W = 15;
	localparam int LEN_W = 15;
	localparam int CYC_W = 10;
	localparam int PCT_W = 7;
	localparam int PROD_W = 22;
	localparam int PCT_FULL = 100;
	localparam int SLOTS = 16;
	localparam int SLOT_W = 4;
	localparam int TRIG_N = 8;
	localparam int ANALOG_W = 16;
	localparam int WORD_W = 24;
	localparam int FIFO_DEPTH = 16;

	// ==========================================
	// Register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TRIG_SEL = 8'h04;
	localparam logic [7:0] REG_LIMIT = 8'h08;
	localparam logic [7:0] REG_PRE_PCT = 8'h0C;
	localparam logic [7:0] REG_POST_PCT = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_REC_SEL = 8'h18;
	localparam logic [7:0] REG_REC_INFO = 8'h1C;
	localparam logic [7:0] REG_RD_OFS = 8'h20;
	localparam logic [7:0] REG_RD_DATA = 8'h24;
	localparam int CTRL_OVERWRITE = 0;
	localparam int CTRL_MANUAL = 1;
	localparam int CTRL_DEL_ONE = 2;
	localparam int CTRL_DEL_ALL = 3;
	localparam int CTRL_CLR_FLAGS = 4;
	localparam int KEY_LSB = 8;
	localparam logic [7:0] DEL_KEY = 8'hA5;
	localparam logic [CYC_W-1:0] LIMIT_RST = 10'h032;
	localparam logic [PCT_W-1:0] PRE_RST = 7'h14;
	localparam logic [PCT_W-1:0] POST_RST = 7'h14;

	typedef enum {ST_IDLE, ST_ROOM, ST_COPY, ST_EVENT, ST_POST, ST_CLOSE} rec_state_e;

endpackage

/* File: rtl/disturbance_capture_recorder.sv */
// Purpose: Disturbance recorder with pre-trigger history and shared record storage.
// Assumes: Analog sample input is on core_clk; trigger lines are asynchronous pins.
// Notes: A record deleted singly keeps its space until dropped as the oldest; delete all frees it at once.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns

// ==========================================
// Sample FIFO
module sample_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Fill side
	input wire logic [WIDTH-1:0] inWord,
	input wire logic inValid,
	output logic inReady,
	// Drain side
	output logic [WIDTH-1:0] outWord,
	output logic outValid,
	input wire logic outReady
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wrPtr_q;
	logic [PW:0] rdPtr_q;

	assign inReady = (wrPtr_q - rdPtr_q) != (PW+1)'(DEPTH);
	assign outValid = wrPtr_q != rdPtr_q;
	assign outWord = mem[rdPtr_q[PW-1:0]];

	always_ff @(posedge core_clk) begin
		if (inValid && inReady) begin
			mem[wrPtr_q[PW-1:0]] <= inWord;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (inValid && inReady) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (outValid && outReady) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end
endmodule

// ==========================================
// Recorder top
module disturbance_capture_recorder #(
	parameter int SAMPLE_DIV = dcr_pkg::SAMPLE_DIV
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [dcr_pkg::ADDR_W-1:0] regAddr,
	input wire logic [dcr_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [dcr_pkg::DATA_W-1:0] regRdData,
	// Channels
	input wire logic [dcr_pkg::TRIG_N-1:0] protSignals,
	input wire logic [dcr_pkg::ANALOG_W-1:0] analogSample,
	// Status
	output logic recording,
	output logic triggerLocked
);
	localparam int SW = dcr_pkg::SADDR_W;
	localparam int HW = dcr_pkg::HADDR_W;
	localparam int LW = dcr_pkg::LEN_W;

	dcr_pkg::rec_state_e state_q;
	logic [dcr_pkg::WORD_W-1:0] store [dcr_pkg::STORE_WORDS];
	logic [dcr_pkg::WORD_W-1:0] hist [dcr_pkg::HIST_WORDS];
	logic [SW-1:0] recStart [dcr_pkg::SLOTS];
	logic [LW-1:0] recLen [dcr_pkg::SLOTS];
	logic [dcr_pkg::SLOTS-1:0] recValid_q;
	logic [dcr_pkg::DIV_W-1:0] divCnt_q;
	logic sampleTick_q;
	logic [dcr_pkg::TRIG_N-1:0] protMeta_q, protSync_q, trigSel_q, lockMask_q;
	logic overwrite_q, manualReq_q, delOneReq_q, delAllReq_q, clrReq_q;
	logic [dcr_pkg::CYC_W-1:0] limitCyc_q;
	logic [dcr_pkg::PCT_W-1:0] prePct_q, postPct_q;
	logic [dcr_pkg::SLOT_W-1:0] recSel_q, oldest_q, newSlot;
	logic [LW-1:0] rdOfs_q, limitLen_q, preLen_q, postLen_q;
	logic [LW-1:0] recCnt_q, postCnt_q, copyCnt_q;
	logic [SW-1:0] head_q, used_q, rdAddr;
	logic [HW-1:0] histPtr_q, copyRd_q;
	logic [dcr_pkg::SLOT_W:0] count_q;
	logic refused_q, overrun_q, recording_q, locked_q;
	logic [dcr_pkg::DATA_W-1:0] regRdData_q, rdMux;
	logic fifoInReady, fifoOutValid, fifoOutReady, pop;
	logic [dcr_pkg::WORD_W-1:0] fifoOut;
	logic trigNow, locked, roomOk, dropOldest, delKeyOk;
	logic [LW-1:0] recNext, postNext;
	logic [dcr_pkg::PROD_W-1:0] preProd, postProd;
	logic [SW:0] freeWords;

	function automatic logic [SW-1:0] storeInc(input logic [SW-1:0] a, input logic [SW-1:0] b);
		logic [SW:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= (SW+1)'(dcr_pkg::STORE_WORDS)) begin
			s = s - (SW+1)'(dcr_pkg::STORE_WORDS);
		end
		return s[SW-1:0];
	endfunction

	function automatic logic [HW-1:0] histInc(input logic [HW-1:0] a);
		return (a == HW'(dcr_pkg::HIST_WORDS - 1)) ? '0 : a + 1'b1;
	endfunction

	// ==========================================
	// Sampling and pin synchronisers
	// [RQ1] Sample strobe divider
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_q <= '0;
			sampleTick_q <= 1'b0;
		end else if (divCnt_q == dcr_pkg::DIV_W'(SAMPLE_DIV - 1)) begin
			divCnt_q <= '0;
			sampleTick_q <= 1'b1;
		end else begin
			divCnt_q <= divCnt_q + 1'b1;
			sampleTick_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			protMeta_q <= '0;
			protSync_q <= '0;
		end else begin
			protMeta_q <= protSignals;
			protSync_q <= protMeta_q;
		end
	end

	// Record pauses during pre-trigger copy; FIFO absorbs the gap
	sample_fifo #(.WIDTH(dcr_pkg::WORD_W), .DEPTH(dcr_pkg::FIFO_DEPTH)) sampleBuf (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.inWord({protSync_q, analogSample}),
		.inValid(sampleTick_q),
		.inReady(fifoInReady),
		.outWord(fifoOut),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady)
	);

	// ==========================================
	// Register writes
	assign delKeyOk = regWrData[dcr_pkg::KEY_LSB +: 8] == dcr_pkg::DEL_KEY;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			overwrite_q <= 1'b0;
			trigSel_q <= '0;
			limitCyc_q <= dcr_pkg::LIMIT_RST;
			prePct_q <= dcr_pkg::PRE_RST;
			postPct_q <= dcr_pkg::POST_RST;
			recSel_q <= '0;
			rdOfs_q <= '0;
			manualReq_q <= 1'b0;
			delOneReq_q <= 1'b0;
			delAllReq_q <= 1'b0;
			clrReq_q <= 1'b0;
		end else begin
			manualReq_q <= 1'b0;
			delOneReq_q <= 1'b0;
			delAllReq_q <= 1'b0;
			clrReq_q <= 1'b0;
			if (regWrStrobe) begin
				case (regAddr)
					dcr_pkg::REG_CTRL: begin
						overwrite_q <= regWrData[dcr_pkg::CTRL_OVERWRITE];
						// [RQ13] Manual trigger request
						manualReq_q <= regWrData[dcr_pkg::CTRL_MANUAL];
						// [RQ14] Delete needs key
						delOneReq_q <= regWrData[dcr_pkg::CTRL_DEL_ONE] & delKeyOk;
						delAllReq_q <= regWrData[dcr_pkg::CTRL_DEL_ALL] & delKeyOk;
						clrReq_q <= regWrData[dcr_pkg::CTRL_CLR_FLAGS];
					end
					dcr_pkg::REG_TRIG_SEL: trigSel_q <= regWrData[dcr_pkg::TRIG_N-1:0];
					// [RQ5] Limit clamped to 1..750 cycles
					dcr_pkg::REG_LIMIT: begin
						if (regWrData[dcr_pkg::CYC_W-1:0] == '0) begin
							limitCyc_q <= dcr_pkg::CYC_W'(1);
						end else if (regWrData[dcr_pkg::CYC_W-1:0] >
							dcr_pkg::CYC_W'(dcr_pkg::LIMIT_CYCLES_MAX)) begin
							limitCyc_q <= dcr_pkg::CYC_W'(dcr_pkg::LIMIT_CYCLES_MAX);
						end else begin
							limitCyc_q <= regWrData[dcr_pkg::CYC_W-1:0];
						end
					end
					dcr_pkg::REG_PRE_PCT: prePct_q <= (regWrData[dcr_pkg::PCT_W-1:0] >
						dcr_pkg::PCT_W'(dcr_pkg::PCT_FULL)) ?
						dcr_pkg::PCT_W'(dcr_pkg::PCT_FULL) : regWrData[dcr_pkg::PCT_W-1:0];
					dcr_pkg::REG_POST_PCT: postPct_q <= (regWrData[dcr_pkg::PCT_W-1:0] >
						dcr_pkg::PCT_W'(dcr_pkg::PCT_FULL)) ?
						dcr_pkg::PCT_W'(dcr_pkg::PCT_FULL) : regWrData[dcr_pkg::PCT_W-1:0];
					dcr_pkg::REG_REC_SEL: recSel_q <= regWrData[dcr_pkg::SLOT_W-1:0];
					dcr_pkg::REG_RD_OFS: rdOfs_q <= regWrData[LW-1:0];
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================
	// Derived lengths
	assign preProd = dcr_pkg::PROD_W'(limitLen_q) * dcr_pkg::PROD_W'(prePct_q);
	assign postProd = dcr_pkg::PROD_W'(limitLen_q) * dcr_pkg::PROD_W'(postPct_q);

	// [RQ6] Percent of limit, rounded down
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			limitLen_q <= '0;
			preLen_q <= '0;
			postLen_q <= '0;
		end else begin
			limitLen_q <= {limitCyc_q, dcr_pkg::SPC_SHIFT'(0)};
			preLen_q <= LW'(preProd / dcr_pkg::PROD_W'(dcr_pkg::PCT_FULL));
			postLen_q <= LW'(postProd / dcr_pkg::PROD_W'(dcr_pkg::PCT_FULL));
		end
	end

	// ==========================================
	// Control decisions
	always_comb begin
		// [RQ2] OR of selected sources
		trigNow = |(trigSel_q & protSync_q);
		// [RQ3] Lockout on causing sources
		locked = |(lockMask_q & protSync_q);
		freeWords = (SW+1)'(dcr_pkg::STORE_WORDS) - {1'b0, used_q};
		// [RQ16] Room measured in words
		roomOk = (freeWords >= (SW+1)'(limitLen_q)) &&
			(count_q < (dcr_pkg::SLOT_W+1)'(dcr_pkg::SLOTS));
		// [RQ11] Drop oldest until room
		dropOldest = (state_q == dcr_pkg::ST_ROOM) && !roomOk && overwrite_q &&
			(count_q != '0);
		// Event takes samples only while the trigger holds, so manual gives zero event unless a selected trigger is active
		fifoOutReady = (state_q == dcr_pkg::ST_IDLE) ||
			(state_q == dcr_pkg::ST_EVENT && trigNow) || (state_q == dcr_pkg::ST_POST);
		pop = fifoOutValid && fifoOutReady;
		recNext = recCnt_q + LW'(pop);
		postNext = postCnt_q + LW'(pop);
		newSlot = oldest_q + count_q[dcr_pkg::SLOT_W-1:0];
	end

	// ==========================================
	// Pre-trigger history
	// [RQ17] Every sample enters the ring
	always_ff @(posedge core_clk) begin
		if (pop) begin
			hist[histPtr_q] <= fifoOut;
		end
	end

	// ==========================================
	// Record storage
	always_ff @(posedge core_clk) begin
		// [RQ15] Copied history, then live samples
		if (state_q == dcr_pkg::ST_COPY && copyCnt_q != preLen_q) begin
			store[head_q] <= hist[copyRd_q];
		end else if (pop && state_q != dcr_pkg::ST_IDLE) begin
			store[head_q] <= fifoOut;
		end
	end

	// ==========================================
	// Capture sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= dcr_pkg::ST_IDLE;
			histPtr_q <= '0;
			copyRd_q <= '0;
			copyCnt_q <= '0;
			recCnt_q <= '0;
			postCnt_q <= '0;
			head_q <= '0;
			lockMask_q <= '0;
		end else begin
			if (pop) begin
				histPtr_q <= histInc(histPtr_q);
			end
			case (state_q)
				dcr_pkg::ST_IDLE: begin
					// [RQ13] Manual joins the source OR
					if ((trigNow && !locked) || manualReq_q) begin
						lockMask_q <= trigSel_q & protSync_q;
						state_q <= dcr_pkg::ST_ROOM;
					end
				end
				dcr_pkg::ST_ROOM: begin
					if (roomOk) begin
						// [RQ7] Start full pre length back
						copyRd_q <= (histPtr_q >= preLen_q) ? histPtr_q - preLen_q :
							HW'(dcr_pkg::HIST_WORDS) - preLen_q + histPtr_q;
						copyCnt_q <= '0;
						state_q <= dcr_pkg::ST_COPY;
					end else if (!dropOldest) begin
						// [RQ12] Refused while full
						state_q <= dcr_pkg::ST_IDLE;
					end
				end
				dcr_pkg::ST_COPY: begin
					if (copyCnt_q == preLen_q) begin
						recCnt_q <= preLen_q;
						postCnt_q <= '0;
						state_q <= (preLen_q >= limitLen_q) ? dcr_pkg::ST_CLOSE :
							dcr_pkg::ST_EVENT;
					end else begin
						copyCnt_q <= copyCnt_q + 1'b1;
						copyRd_q <= histInc(copyRd_q);
						head_q <= storeInc(head_q, SW'(1));
					end
				end
				dcr_pkg::ST_EVENT: begin
					lockMask_q <= lockMask_q | (trigSel_q & protSync_q);
					recCnt_q <= recNext;
					if (pop) begin
						head_q <= storeInc(head_q, SW'(1));
					end
					// [RQ8] Event ends at trigger or limit
					if (recNext >= limitLen_q) begin
						state_q <= dcr_pkg::ST_CLOSE;
					end else if (!trigNow) begin
						state_q <= (postLen_q == '0) ? dcr_pkg::ST_CLOSE : dcr_pkg::ST_POST;
					end
				end
				dcr_pkg::ST_POST: begin
					recCnt_q <= recNext;
					postCnt_q <= postNext;
					if (pop) begin
						head_q <= storeInc(head_q, SW'(1));
					end
					// [RQ9] Post ends at post length
					// [RQ10] or at the record limit
					if (recNext >= limitLen_q || postNext >= postLen_q) begin
						state_q <= dcr_pkg::ST_CLOSE;
					end
				end
				dcr_pkg::ST_CLOSE: state_q <= dcr_pkg::ST_IDLE;
				default: state_q <= dcr_pkg::ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// Record table
	always_ff @(posedge core_clk) begin
		if (state_q == dcr_pkg::ST_ROOM && roomOk) begin
			recStart[newSlot] <= head_q;
		end
		if (state_q == dcr_pkg::ST_CLOSE) begin
			recLen[newSlot] <= recCnt_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			recValid_q <= '0;
			oldest_q <= '0;
			count_q <= '0;
			used_q <= '0;
		end else if (state_q == dcr_pkg::ST_CLOSE) begin
			// [RQ4] Shared pool accounting
			recValid_q[newSlot] <= 1'b1;
			count_q <= count_q + 1'b1;
			used_q <= used_q + SW'(recCnt_q);
		end else if (dropOldest) begin
			// [RQ11] Oldest record released
			recValid_q[oldest_q] <= 1'b0;
			oldest_q <= oldest_q + 1'b1;
			count_q <= count_q - 1'b1;
			used_q <= used_q - SW'(recLen[oldest_q]);
		end else if (state_q == dcr_pkg::ST_IDLE) begin
			// [RQ14] Delete all or selected
			if (delAllReq_q) begin
				recValid_q <= '0;
				count_q <= '0;
				used_q <= '0;
			end else if (delOneReq_q && {1'b0, recSel_q} < count_q) begin
				recValid_q[oldest_q + recSel_q] <= 1'b0;
			end
		end
	end

	// ==========================================
	// Flags and status outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			refused_q <= 1'b0;
			overrun_q <= 1'b0;
			recording_q <= 1'b0;
			locked_q <= 1'b0;
		end else begin
			// Set beats clear on the same edge
			refused_q <= (refused_q && !clrReq_q) ||
				(state_q == dcr_pkg::ST_ROOM && !roomOk && !dropOldest);
			overrun_q <= (overrun_q && !clrReq_q) || (sampleTick_q && !fifoInReady);
			recording_q <= state_q != dcr_pkg::ST_IDLE;
			locked_q <= locked;
		end
	end

	assign recording = recording_q;
	assign triggerLocked = locked_q;

	// ==========================================
	// Register reads
	assign rdAddr = storeInc(recStart[oldest_q + recSel_q], SW'(rdOfs_q));

	always_comb begin
		case (regAddr)
			dcr_pkg::REG_CTRL: rdMux = dcr_pkg::DATA_W'(overwrite_q);
			dcr_pkg::REG_TRIG_SEL: rdMux = dcr_pkg::DATA_W'(trigSel_q);
			dcr_pkg::REG_LIMIT: rdMux = dcr_pkg::DATA_W'(limitCyc_q);
			dcr_pkg::REG_PRE_PCT: rdMux = dcr_pkg::DATA_W'(prePct_q);
			dcr_pkg::REG_POST_PCT: rdMux = dcr_pkg::DATA_W'(postPct_q);
			dcr_pkg::REG_STATUS: rdMux = dcr_pkg::DATA_W'({count_q, refused_q, overrun_q,
				locked_q, recording_q});
			dcr_pkg::REG_REC_SEL: rdMux = dcr_pkg::DATA_W'(recSel_q);
			dcr_pkg::REG_REC_INFO: rdMux = dcr_pkg::DATA_W'({recValid_q[oldest_q + recSel_q],
				recLen[oldest_q + recSel_q]});
			dcr_pkg::REG_RD_OFS: rdMux = dcr_pkg::DATA_W'(rdOfs_q);
			dcr_pkg::REG_RD_DATA: rdMux = dcr_pkg::DATA_W'(store[rdAddr]);
			default: rdMux = '0;
		endcase
	end

	// Data valid only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData_q <= '0;
		end else begin
			regRdData_q <= regRdStrobe ? rdMux : '0;
		end
	end

	assign regRdData = regRdData_q;
endmodule

/* File: verif/dcr_chk.sv */
// Purpose: Port-level assertions for the disturbance capture recorder.
// Assumes: Register writes to the limit are not made while recording.
// Notes: Limit shadow applies the same clamp of 1..750 cycles.
`timescale 1ns/1ns

module dcr_chk #(
	parameter int SAMPLE_DIV = dcr_pkg::SAMPLE_DIV
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [dcr_pkg::ADDR_W-1:0] regAddr,
	input wire logic [dcr_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	input wire logic [dcr_pkg::DATA_W-1:0] regRdData,
	// Channels
	input wire logic [dcr_pkg::TRIG_N-1:0] protSignals,
	input wire logic [dcr_pkg::ANALOG_W-1:0] analogSample,
	// Status
	input wire logic recording,
	input wire logic triggerLocked
);
	logic [9:0] limitQ;
	logic [31:0] recRunQ;
	logic [31:0] recMax;
	logic [3:0] causeAgeQ;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ==========================================
	// Helper logic
	// Slack covers room search and pre copy at one word per clock
	assign recMax = 32'(limitQ) * 32'(32 * (SAMPLE_DIV + 1)) + 32'h28;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			limitQ <= dcr_pkg::LIMIT_RST;
		end else if (regWrStrobe && regAddr == dcr_pkg::REG_LIMIT) begin
			if (regWrData[9:0] == 10'h000) begin
				limitQ <= 10'h001;
			end else if (regWrData[9:0] > 10'h2EE) begin
				limitQ <= 10'h2EE;
			end else begin
				limitQ <= regWrData[9:0];
			end
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			recRunQ <= 32'h0;
		end else begin
			recRunQ <= recording ? recRunQ + 32'h1 : 32'h0;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			causeAgeQ <= 4'hF;
		end else if (protSignals != 8'h00 || (regWrStrobe && regAddr == dcr_pkg::REG_CTRL
				&& regWrData[dcr_pkg::CTRL_MANUAL])) begin
			causeAgeQ <= 4'h0;
		end else if (causeAgeQ != 4'hF) begin
			causeAgeQ <= causeAgeQ + 4'h1;
		end
	end

	// ==========================================
	// Assertions
	a_rd_quiet: assert property (!$past(regRdStrobe) |-> regRdData == 32'h0)
		else $error("read data not zero outside read slot");
	a_rd_unmapped: assert property ($past(regRdStrobe) && $past(regAddr) > 8'h24
		|-> regRdData == 32'h0) else $error("unmapped read not zero");
	a_limit_readback: assert property (
		$past(regRdStrobe) && $past(regAddr) == dcr_pkg::REG_LIMIT
		|-> regRdData == {22'h0, limitQ}) else $error("limit readback wrong");
	a_lock_clears: assert property ((protSignals == 8'h00) [*4] |=> !triggerLocked)
		else $error("lock held with all pins idle");
	a_lock_with_rec: assert property ($rose(triggerLocked) |-> ##[0:4] recording)
		else $error("lock rose without a record");
	a_start_has_cause: assert property ($rose(recording) |-> causeAgeQ <= 4'h8)
		else $error("record started without trigger or manual");
	a_rec_bounded: assert property (recRunQ <= recMax)
		else $error("record ran past its length limit");
	a_count_slots: assert property (
		$past(regRdStrobe) && $past(regAddr) == dcr_pkg::REG_STATUS
		|-> regRdData[8:4] <= 5'h10) else $error("record count above slot count");
endmodule

bind disturbance_capture_recorder dcr_chk #(.SAMPLE_DIV(SAMPLE_DIV)) chk (
	.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
	.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
	.protSignals(protSignals), .analogSample(analogSample), .recording(recording),
	.triggerLocked(triggerLocked));

/* File: verif/front_end_model.sv */
// Purpose: Far-side model of the protection signal pins and the sample front end.
// Assumes: Pin levels are commanded by the bench; analog value is a free ramp.
// Notes: Ramp steps every core clock, so stored samples differ by the divider.
`timescale 1ns/1ns

module front_end_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bench command
	input wire logic [7:0] pinLevels,
	// Pins toward the recorder
	output logic [7:0] protSignals,
	output logic [15:0] analogSample
);
	// ==========================================
	// Front end
	// Ramp makes sample cadence visible in stored data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			analogSample <= 16'h0000;
		end else begin
			analogSample <= analogSample + 16'h0001;
		end
	end
	assign protSignals = pinLevels;
endmodule

/* File: verif/tb_disturbance_capture_recorder.sv */
// Purpose: Self-checking bench for the disturbance capture recorder.
// Assumes: Divider of 8, limit 1 cycle (32 samples), pre and post 25 % (8 samples).
// Notes: Manual record is 16 words, held-trigger record is 32 words.
`timescale 1ns/1ns

module tb_disturbance_capture_recorder;
	localparam int SDIV = 8;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic regWrStrobe = 1'b0;
	logic regRdStrobe = 1'b0;
	logic [31:0] regRdData;
	logic [7:0] pinLevels = 8'h00;
	logic [7:0] protSignals;
	logic [15:0] analogSample;
	logic recording;
	logic triggerLocked;
	int failures = 0;
	int checked = 0;

	always #5 core_clk = ~core_clk;

	front_end_model fe (.core_clk(core_clk), .rst_n(rst_n), .pinLevels(pinLevels),
		.protSignals(protSignals), .analogSample(analogSample));
	disturbance_capture_recorder #(.SAMPLE_DIV(SDIV)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
		.regRdStrobe(regRdStrobe), .regRdData(regRdData), .protSignals(protSignals),
		.analogSample(analogSample), .recording(recording), .triggerLocked(triggerLocked));

	// ==========================================
	// Shared tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task close_out;
		if (failures == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge core_clk);
		regWrStrobe <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge core_clk);
		regRdStrobe <= 1'b0;
		#1 d = regRdData;
	endtask
	task rdCheck(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		check(d, exp);
	endtask
	task countIs(input logic [4:0] n);
		logic [31:0] d;
		rd(dcr_pkg::REG_STATUS, d);
		check({27'h0, d[8:4]}, {27'h0, n});
	endtask
	task cycles(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task waitEdge(input logic lvl, input int bound);
		int i;
		for (i = 0; i < bound && recording !== lvl; i++) @(posedge core_clk);
		if (recording !== lvl) begin
			failures++;
			close_out();
		end
	endtask
	task waitRecord;
		waitEdge(1'b1, 60);
		waitEdge(1'b0, 3000);
		cycles(2);
	endtask
	task word(input logic [14:0] ofs, output logic [31:0] d);
		wr(dcr_pkg::REG_RD_OFS, {17'h0, ofs});
		rd(dcr_pkg::REG_RD_DATA, d);
	endtask

	// ==========================================
	// Scenarios
	task regsScenario;
		rdCheck(dcr_pkg::REG_LIMIT, 32'h32);
		rdCheck(dcr_pkg::REG_PRE_PCT, 32'h14);
		rdCheck(dcr_pkg::REG_POST_PCT, 32'h14);
		rdCheck(8'hFC, 32'h0);
		wr(dcr_pkg::REG_LIMIT, 32'h0);
		rdCheck(dcr_pkg::REG_LIMIT, 32'h1);
		wr(dcr_pkg::REG_LIMIT, 32'h3E8);
		rdCheck(dcr_pkg::REG_LIMIT, 32'h2EE);
		wr(dcr_pkg::REG_PRE_PCT, 32'h7F);
		rdCheck(dcr_pkg::REG_PRE_PCT, 32'h64);
		wr(dcr_pkg::REG_LIMIT, 32'h1);
		wr(dcr_pkg::REG_PRE_PCT, 32'h19);
		wr(dcr_pkg::REG_POST_PCT, 32'h19);
	endtask
	task manualScenario;
		logic [31:0] d;
		logic [31:0] prev;
		wr(dcr_pkg::REG_CTRL, 32'h2);
		waitRecord();
		countIs(5'h01);
		rdCheck(dcr_pkg::REG_REC_INFO, 32'h8010);
		prev = 32'h0;
		for (int k = 0; k < 16; k++) begin
			word(15'(k), d);
			check({16'h0, d[31:16]}, 32'h0);
			if (k > 0) check({16'h0, d[15:0] - prev[15:0]}, 32'(SDIV));
			prev = d;
		end
	endtask
	task triggerScenario;
		logic [31:0] d;
		wr(dcr_pkg::REG_TRIG_SEL, 32'h80);
		@(posedge core_clk) pinLevels <= 8'h80;
		waitRecord();
		countIs(5'h02);
		wr(dcr_pkg::REG_REC_SEL, 32'h1);
		rdCheck(dcr_pkg::REG_REC_INFO, 32'h8020);
		word(15'h0, d);
		check({31'h0, d[23]}, 32'h0);
		word(15'h1F, d);
		check({31'h0, d[23]}, 32'h1);
		cycles(400);
		check({31'h0, triggerLocked}, 32'h1);
		countIs(5'h02);
		@(posedge core_clk) pinLevels <= 8'h01;
		cycles(300);
		check({31'h0, triggerLocked}, 32'h0);
		countIs(5'h02);
		@(posedge core_clk) pinLevels <= 8'h00;
	endtask
	task storageScenario;
		logic [31:0] d;
		wr(dcr_pkg::REG_REC_SEL, 32'h0);
		wr(dcr_pkg::REG_CTRL, 32'hA504);
		cycles(4);
		rd(dcr_pkg::REG_REC_INFO, d);
		check({31'h0, d[15]}, 32'h0);
		repeat (14) begin
			wr(dcr_pkg::REG_CTRL, 32'h2);
			waitRecord();
		end
		countIs(5'h10);
		wr(dcr_pkg::REG_CTRL, 32'h2);
		cycles(300);
		rd(dcr_pkg::REG_STATUS, d);
		check({23'h0, d[8:3]}, 32'h21);
		wr(dcr_pkg::REG_CTRL, 32'h3);
		waitRecord();
		countIs(5'h10);
		rdCheck(dcr_pkg::REG_REC_INFO, 32'h8020);
		wr(dcr_pkg::REG_REC_SEL, 32'hF);
		rdCheck(dcr_pkg::REG_REC_INFO, 32'h8010);
		wr(dcr_pkg::REG_CTRL, 32'h9);
		cycles(4);
		countIs(5'h10);
		wr(dcr_pkg::REG_CTRL, 32'hA509);
		cycles(4);
		countIs(5'h00);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		cycles(16);
		rst_n <= 1'b1;
		cycles(2);
		regsScenario();
		// History must fill before the first record
		cycles(400);
		manualScenario();
		triggerScenario();
		storageScenario();
		close_out();
	end
endmodule
